// File: pkg/bff_pkg.sv
// constants, carrier types and parity helpers for the flag and parity block
package bff_pkg;

  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int BFF_DEPTH_DEF = 512;
  localparam int BFF_OFS_W_DEF = 9;
  localparam int BFF_PACK_W = 9;
  localparam int BFF_WORD_W = 36;
  localparam int BFF_BYTE_W = 9;
  localparam int BFF_NBYTE = 4;
  localparam int BFF_CFG_W = 18;
  localparam int BFF_OFS_RST = 8;
  localparam logic [17:0] BFF_CFG_RST = 18'h00001;

  // ---------------------------------------------------------------
  // configuration word bit positions
  // ---------------------------------------------------------------
  localparam int BFF_B_PSENSE = 0;
  localparam int BFF_B_GEN_A = 1;
  localparam int BFF_B_LAT_A = 2;
  localparam int BFF_B_SY_EF2 = 3;
  localparam int BFF_B_SY_AE2 = 4;
  localparam int BFF_B_HF1_LO = 5;
  localparam int BFF_B_HF1_HI = 6;
  localparam int BFF_B_SY_AF1 = 7;
  localparam int BFF_B_SY_FF1 = 8;
  localparam int BFF_B_CHK_B = 9;
  localparam int BFF_B_GEN_B = 10;
  localparam int BFF_B_LAT_B = 11;
  localparam int BFF_B_SY_EF1 = 12;
  localparam int BFF_B_SY_AE1 = 13;
  localparam int BFF_B_HF2_LO = 14;
  localparam int BFF_B_HF2_HI = 15;
  localparam int BFF_B_SY_AF2 = 16;
  localparam int BFF_B_SY_FF2 = 17;

  // ---------------------------------------------------------------
  // port A resource addresses
  // ---------------------------------------------------------------
  localparam logic [2:0] BFF_A_FIFO = 3'h7;
  localparam logic [2:0] BFF_A_MBOX = 3'h6;
  localparam logic [2:0] BFF_A_FLAGW = 3'h5;
  localparam logic [2:0] BFF_A_CTRL = 3'h4;
  localparam logic [2:0] BFF_A_AE1 = 3'h3;
  localparam logic [2:0] BFF_A_AF1 = 3'h2;
  localparam logic [2:0] BFF_A_AE2 = 3'h1;
  localparam logic [2:0] BFF_A_AF2 = 3'h0;

  // ---------------------------------------------------------------
  // port B width codes and check masks
  // ---------------------------------------------------------------
  localparam logic [1:0] BFF_WS_36 = 2'h3;
  localparam logic [1:0] BFF_WS_36R = 2'h2;
  localparam logic [1:0] BFF_WS_18 = 2'h1;
  localparam logic [1:0] BFF_WS_9 = 2'h0;
  localparam logic [3:0] BFF_MASK_ALL = 4'hF;
  localparam logic [3:0] BFF_MASK_HALF = 4'h3;
  localparam logic [3:0] BFF_MASK_BYTE = 4'h1;

  // ---------------------------------------------------------------
  // flag indices
  // ---------------------------------------------------------------
  localparam int BFF_FL_FF = 0;
  localparam int BFF_FL_AF = 1;
  localparam int BFF_FL_HF = 2;
  localparam int BFF_FL_AE = 3;
  localparam int BFF_FL_EF = 4;
  localparam int BFF_NFLAG = 5;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ef;
    logic ae;
    logic hf;
    logic af;
    logic ff;
  } bff_flags_t;

  typedef struct packed {
    logic en;
    logic rd;
    logic [2:0] addr;
    logic [35:0] data;
  } bff_porta_req_t;

  // ---------------------------------------------------------------
  // parity helpers
  // ---------------------------------------------------------------
  function automatic logic [35:0] bff_par_gen(input logic [35:0] d, input logic odd);
    logic [35:0] o;
    o = d;
    for (int i = 0; i < BFF_NBYTE; i++) begin
      o[i*BFF_BYTE_W+8] = (^d[i*BFF_BYTE_W +: 8]) ^ odd;
    end
    return o;
  endfunction : bff_par_gen

  function automatic logic [3:0] bff_par_err(input logic [35:0] d, input logic odd);
    logic [3:0] e;
    e = '0;
    for (int i = 0; i < BFF_NBYTE; i++) begin
      e[i] = (^d[i*BFF_BYTE_W +: BFF_BYTE_W]) ^ odd;
    end
    return e;
  endfunction : bff_par_err

endpackage : bff_pkg

// File: testbench/bff_far_end.sv
// far-side model: port A and port B bus masters with their own clocks
`timescale 1ns/10ps
module bff_far_end
  import bff_pkg::*;
(
  output logic a_clk_o,
  output logic b_clk_o,
  output bff_porta_req_t a_req_o,
  output logic [35:0] b_data_o,
  output logic [1:0] push_o,
  output logic [1:0] pop_o
);
  // -------------------------------------------------------------
  // port clocks, free running, same period, B lagging A by 30 ns
  // -------------------------------------------------------------
  initial begin
    a_clk_o = 1'b0;
    forever #80 a_clk_o = ~a_clk_o;
  end
  initial begin
    b_clk_o = 1'b0;
    #30;
    forever #80 b_clk_o = ~b_clk_o;
  end
  // idle bus values at time zero
  initial begin
    a_req_o = '0;
    b_data_o = '0;
    push_o = '0;
    pop_o = '0;
  end
  // one register access held across exactly one A rise
  task automatic reg_acc(input logic rd, input logic [2:0] addr, input logic [35:0] d);
    @(negedge a_clk_o);
    a_req_o = '{en: 1'b1, rd: rd, addr: addr, data: d};
    @(negedge a_clk_o);
    a_req_o = '{en: 1'b0, rd: ~rd, addr: ~addr, data: ~d};
  endtask : reg_acc
  // park a value on the idle port A data bus
  task automatic a_hold(input logic [35:0] d);
    @(negedge a_clk_o);
    a_req_o.data = d;
  endtask : a_hold
  // port B data changes just after a B fall
  task automatic b_hold(input logic [35:0] d);
    @(negedge b_clk_o);
    b_data_o = d;
  endtask : b_hold
  // one window holding one A rise and one B rise
  task automatic step(input logic [1:0] pu, input logic [1:0] po);
    @(negedge a_clk_o);
    push_o = pu;
    pop_o = po;
    @(negedge a_clk_o);
    push_o = '0;
    pop_o = '0;
  endtask : step
endmodule : bff_far_end

// File: testbench/bff_flag_parity_bench.sv
// self-checking bench for the flag, offset and parity block
`timescale 1ns/10ps
module bff_flag_parity_bench
  import bff_pkg::*;
;
  localparam int DEPTH = 16;
  localparam logic [35:0] W_FIG = 36'h9E0F27038;
  localparam logic [35:0] W_GOOD = 36'h804020100;
  logic ref_clk;
  logic rst;
  logic a_clk;
  logic b_clk;
  bff_porta_req_t a_req;
  logic [35:0] b_data;
  logic [1:0] push;
  logic [1:0] pop;
  logic [1:0] ws;
  logic [35:0] rd_data;
  logic [35:0] gen_a;
  logic [35:0] gen_b;
  logic pf_a_n;
  logic pf_b_n;
  bff_flags_t fl1_n;
  bff_flags_t fl2_n;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [35:0] cfgs [3] = '{36'h00001, 36'h371B9, 36'h08041};

  // -------------------------------------------------------------
  // design, far side, clock and timeout
  // -------------------------------------------------------------
  bff_flag_parity #(.DEPTH(DEPTH)) dut (
    .REF_CLK_I(ref_clk), .RST_I(rst), .PORT_A_CLK_I(a_clk), .PORT_B_CLK_I(b_clk),
    .EN_A_I(a_req.en), .RD_A_I(a_req.rd), .ADDR_A_I(a_req.addr), .DATA_A_I(a_req.data),
    .DATA_B_I(b_data), .PORTB_WIDTH_SEL_I(ws), .PUSH_I(push), .POP_I(pop),
    .DATA_A_O(rd_data), .GEN_A_O(gen_a), .GEN_B_O(gen_b), .PARITY_ERROR_FLAG_A_N_O(pf_a_n),
    .PARITY_ERROR_FLAG_B_N_O(pf_b_n), .FLAGS1_N_O(fl1_n), .FLAGS2_N_O(fl2_n));
  bff_far_end u_far (.a_clk_o(a_clk), .b_clk_o(b_clk), .a_req_o(a_req), .b_data_o(b_data),
    .push_o(push), .pop_o(pop));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      finish_test();
    end
  end

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [2:0] addr, input logic [35:0] d);
    u_far.reg_acc(1'b0, addr, d);
  endtask : wr
  task automatic rd(input logic [2:0] addr);
    u_far.reg_acc(1'b1, addr, 36'h000000000);
  endtask : rd
  // let an A rise, a B rise and the input sync pass
  task automatic settle();
    @(posedge a_clk);
    @(posedge b_clk);
    repeat (6) @(negedge ref_clk);
  endtask : settle
  function automatic bff_flags_t exp_fl(input int n, input int q, input int p);
    bff_flags_t f;
    f.ef = (n != 0);
    f.ae = (n > q);
    f.hf = !(n > DEPTH / 2);
    f.af = !(n + p >= DEPTH);
    f.ff = (n != DEPTH);
    return f;
  endfunction : exp_fl
  // error flag level: low when a checked byte has the wrong ones count
  function automatic logic pf_exp(input logic [35:0] d, input logic odd, input logic [3:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (m[i] && ((^d[i*9 +: 9]) != odd)) ok = 1'b0;
    end
    return ok;
  endfunction : pf_exp

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_regs();
    rd(BFF_A_CTRL);
    check(rd_data, 36'h000000001);
    for (int i = 0; i < 4; i++) begin
      rd(3'(i));
      check(rd_data, 36'h000000008);
    end
    check({31'h0, fl1_n}, {31'h0, exp_fl(0, 8, 8)});
    wr(BFF_A_CTRL, 36'hFFFFFFFFF);
    rd(BFF_A_CTRL);
    check(rd_data, 36'h00003FFFF);
    wr(BFF_A_FLAGW, {9'h008, 9'h008, 9'h005, 9'h003});
    wr(BFF_A_MBOX, 36'h123456789);
    rd(BFF_A_MBOX);
    check(rd_data, 36'h000000000);
    for (int i = 0; i < 4; i++) begin
      rd(3'(i));
      check(rd_data, (i == 3) ? 36'h3 : (i == 2) ? 36'h5 : 36'h8);
    end
    $display("test registers done");
  endtask : t_regs
  task automatic t_parity();
    for (int odd = 0; odd < 2; odd++) begin
      wr(BFF_A_CTRL, {34'h0, 1'b1, 1'(odd)});
      u_far.a_hold(W_FIG);
      settle();
      check(gen_a, odd ? 36'h9E4F07038 : 36'h1E0F27138);
      check({35'h0, pf_a_n}, {35'h0, pf_exp(W_FIG, 1'(odd), BFF_MASK_ALL)});
      u_far.a_hold(W_GOOD);
      settle();
      check({35'h0, pf_a_n}, {35'h0, pf_exp(W_GOOD, 1'(odd), BFF_MASK_ALL)});
    end
    wr(BFF_A_CTRL, 36'h00401);
    u_far.a_hold(W_FIG);
    u_far.b_hold(W_FIG);
    settle();
    check(gen_a, W_FIG);
    check(gen_b, 36'h9E4F07038);
    $display("test parity done");
  endtask : t_parity
  task automatic t_check_b();
    for (int chk = 0; chk < 2; chk++) begin
      wr(BFF_A_CTRL, chk ? 36'h00201 : 36'h00001);
      u_far.b_hold(36'h000020100);
      for (int w = 0; w < 4; w++) begin
        @(negedge ref_clk);
        ws = 2'(w);
        settle();
        check({35'h0, pf_b_n}, {35'h0, 1'(chk != 0 && w < 2)});
      end
    end
    ws = BFF_WS_36;
    $display("test port B check policy done");
  endtask : t_check_b
  task automatic t_latch_b();
    wr(BFF_A_CTRL, 36'h00801);
    u_far.b_hold(W_GOOD);
    settle();
    check({35'h0, pf_b_n}, 36'h1);
    u_far.b_hold(36'h000000100);
    repeat (6) @(negedge ref_clk);
    check({35'h0, pf_b_n}, 36'h1);
    @(posedge b_clk);
    repeat (6) @(negedge ref_clk);
    check({35'h0, pf_b_n}, 36'h0);
    // port A flag latched on its own clock
    wr(BFF_A_CTRL, 36'h00005);
    u_far.a_hold(W_GOOD);
    settle();
    check({35'h0, pf_a_n}, 36'h1);
    u_far.a_hold(W_FIG);
    repeat (6) @(negedge ref_clk);
    check({35'h0, pf_a_n}, 36'h1);
    @(posedge a_clk);
    repeat (6) @(negedge ref_clk);
    check({35'h0, pf_a_n}, 36'h0);
    wr(BFF_A_CTRL, 36'h00001);
    u_far.b_hold(W_GOOD);
    repeat (6) @(negedge ref_clk);
    check({35'h0, pf_b_n}, 36'h1);
    $display("test latched flag done");
  endtask : t_latch_b
  // fill past full, then drain past empty, in one clocking mode
  task automatic t_flags(input logic [35:0] cfg);
    int n;
    wr(BFF_A_CTRL, cfg);
    for (int i = 1; i <= 2 * DEPTH + 2; i++) begin
      if (i <= DEPTH + 1) begin
        u_far.step(2'h3, 2'h0);
        n = (i > DEPTH) ? DEPTH : i;
      end else begin
        u_far.step(2'h0, 2'h3);
        n = (2 * DEPTH + 1 - i < 0) ? 0 : 2 * DEPTH + 1 - i;
      end
      settle();
      check({31'h0, fl1_n}, {31'h0, exp_fl(n, 3, 5)});
      check({31'h0, fl2_n}, {31'h0, exp_fl(n, 8, 8)});
    end
    $display("test flags done, config %h", cfg);
  endtask : t_flags

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ws = BFF_WS_36;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_regs();
    t_parity();
    t_check_b();
    t_latch_b();
    for (int c = 0; c < 3; c++) begin
      t_flags(cfgs[c]);
    end
    finish_test();
  end
endmodule : bff_flag_parity_bench

// File: verilog/bff_flag_parity.sv
// flag generation, offsets, configuration and byte parity for the two-way fifo
`timescale 1ns/10ps
// Functional notes
// - reset loads all four offsets with eight
// - packed flag word holds four 9-bit offsets
// - bit 00 picks parity sense, resets odd
// - checked byte correct by odd/even ones count
// - generation bit overwrites byte top parity bit
// - latch bit: flowthrough or port-clocked error flag
// - latched port B flag stays steady
// - bit 09 selects full-word or width-based check
// - almost-empty low while readable count at most q
// - almost-full low while free space at most p
// - sync bit: one clock or two clocks
// - half-full two-bit field picks clocking
// - other configuration bits reset to zero
// - set on rise; clear on fall then rise
module bff_flag_parity
  import bff_pkg::*;
#(
  parameter int DEPTH = BFF_DEPTH_DEF,
  parameter int OFS_W = BFF_OFS_W_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PORT_A_CLK_I,
  input wire logic PORT_B_CLK_I,
  input wire logic EN_A_I,
  input wire logic RD_A_I,
  input wire logic [2:0] ADDR_A_I,
  input wire logic [35:0] DATA_A_I,
  input wire logic [35:0] DATA_B_I,
  input wire logic [1:0] PORTB_WIDTH_SEL_I,
  input wire logic [1:0] PUSH_I,
  input wire logic [1:0] POP_I,
  output logic [35:0] DATA_A_O,
  output logic [35:0] GEN_A_O,
  output logic [35:0] GEN_B_O,
  output logic PARITY_ERROR_FLAG_A_N_O,
  output logic PARITY_ERROR_FLAG_B_N_O,
  output bff_flags_t FLAGS1_N_O,
  output bff_flags_t FLAGS2_N_O
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW:0] DEPTH_X = (CW+1)'(DEPTH);
  localparam int SW = ((CW > OFS_W) ? CW : OFS_W) + 2; // room for count plus offset

  typedef struct packed {
    logic [2:0] ca;
    logic [2:0] cb;
    bff_porta_req_t a1;
    bff_porta_req_t a2;
    logic [35:0] b1;
    logic [35:0] b2;
    logic [1:0] ws1;
    logic [1:0] ws2;
    logic [1:0] pu1;
    logic [1:0] pu2;
    logic [1:0] po1;
    logic [1:0] po2;
    logic [1:0][CW-1:0] cnt;
    logic [17:0] cfg;
    logic [1:0][OFS_W-1:0] aeo;
    logic [1:0][OFS_W-1:0] afo;
    logic [35:0] rdat;
    logic [35:0] gena;
    logic [35:0] genb;
    logic pfa;
    logic pfb;
  } bff_state_t;

  bff_state_t st_r;
  bff_state_t st_nxt;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [3:0] err_a;
  logic [3:0] err_b;
  logic [3:0] mask_b;
  logic now_a;
  logic now_b;
  logic wr_a;
  logic [9:0] cond;
  logic [9:0] setr;
  logic [9:0] clrr;
  logic [9:0] clrf;
  logic [9:0] flags_n;
  logic [1:0][4:0] sy;
  logic [1:0][4:0] sk;

  default clocking cb_ref @(posedge REF_CLK_I);
  endclocking

  // ---------------------------------------------------------------
  // port clock edges and parity terms
  // ---------------------------------------------------------------
  // edges seen from the second and third sync stages only
  assign rise = {st_r.cb[1] & ~st_r.cb[2], st_r.ca[1] & ~st_r.ca[2]};
  assign fall = {~st_r.cb[1] & st_r.cb[2], ~st_r.ca[1] & st_r.ca[2]};
  assign wr_a = rise[0] && st_r.a2.en && !st_r.a2.rd;
  assign err_a = bff_par_err(st_r.a2.data, st_r.cfg[BFF_B_PSENSE]);
  assign err_b = bff_par_err(st_r.b2, st_r.cfg[BFF_B_PSENSE]);

  // port B check lanes from the width setting
  always_comb begin
    mask_b = BFF_MASK_ALL;
    if (st_r.cfg[BFF_B_CHK_B]) begin
      case (st_r.ws2)
        BFF_WS_18: mask_b = BFF_MASK_HALF;
        BFF_WS_9: mask_b = BFF_MASK_BYTE;
        default: mask_b = BFF_MASK_ALL;
      endcase
    end
  end

  assign now_a = |err_a;
  assign now_b = |(err_b & mask_b);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic psh;
    logic pop;
    psh = 1'b0;
    pop = 1'b0;
    st_nxt = st_r;
    st_nxt.ca = {st_r.ca[1:0], PORT_A_CLK_I};
    st_nxt.cb = {st_r.cb[1:0], PORT_B_CLK_I};
    st_nxt.a1 = '{en: EN_A_I, rd: RD_A_I, addr: ADDR_A_I, data: DATA_A_I};
    st_nxt.a2 = st_r.a1;
    st_nxt.b1 = DATA_B_I;
    st_nxt.b2 = st_r.b1;
    st_nxt.ws1 = PORTB_WIDTH_SEL_I;
    st_nxt.ws2 = st_r.ws1;
    st_nxt.pu1 = PUSH_I;
    st_nxt.pu2 = st_r.pu1;
    st_nxt.po1 = POP_I;
    st_nxt.po2 = st_r.po1;
    // occupancy: fifo 0 written on A and read on B, fifo 1 the reverse
    for (int f = 0; f < 2; f++) begin
      psh = rise[f] && st_r.pu2[f] && ({1'b0, st_r.cnt[f]} != DEPTH_X);
      pop = rise[1-f] && st_r.po2[f] && (st_r.cnt[f] != '0);
      if (psh && !pop) begin
        st_nxt.cnt[f] = st_r.cnt[f] + 1'b1;
      end else if (pop && !psh) begin
        st_nxt.cnt[f] = st_r.cnt[f] - 1'b1;
      end
    end
    // generated data words
    st_nxt.gena = st_r.cfg[BFF_B_GEN_A] ?
      bff_par_gen(st_r.a2.data, st_r.cfg[BFF_B_PSENSE]) : st_r.a2.data;
    st_nxt.genb = st_r.cfg[BFF_B_GEN_B] ?
      bff_par_gen(st_r.b2, st_r.cfg[BFF_B_PSENSE]) : st_r.b2;
    // latched error flags sample on their own port edge
    if (rise[0]) begin
      st_nxt.pfa = now_a;
    end
    if (rise[1]) begin
      st_nxt.pfb = now_b;
    end
    // register writes through the port A address code
    if (wr_a) begin
      case (st_r.a2.addr)
        BFF_A_CTRL: st_nxt.cfg = st_r.a2.data[BFF_CFG_W-1:0];
        BFF_A_FLAGW: begin
          st_nxt.aeo[0] = OFS_W'(st_r.a2.data[0 +: BFF_PACK_W]);
          st_nxt.afo[0] = OFS_W'(st_r.a2.data[BFF_PACK_W +: BFF_PACK_W]);
          st_nxt.aeo[1] = OFS_W'(st_r.a2.data[2*BFF_PACK_W +: BFF_PACK_W]);
          st_nxt.afo[1] = OFS_W'(st_r.a2.data[3*BFF_PACK_W +: BFF_PACK_W]);
        end
        BFF_A_AE1: st_nxt.aeo[0] = st_r.a2.data[OFS_W-1:0];
        BFF_A_AF1: st_nxt.afo[0] = st_r.a2.data[OFS_W-1:0];
        BFF_A_AE2: st_nxt.aeo[1] = st_r.a2.data[OFS_W-1:0];
        BFF_A_AF2: st_nxt.afo[1] = st_r.a2.data[OFS_W-1:0];
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end
    // register reads; fifo and mailbox codes return zero here
    if (rise[0] && st_r.a2.en && st_r.a2.rd) begin
      case (st_r.a2.addr)
        BFF_A_CTRL: st_nxt.rdat = BFF_WORD_W'(st_r.cfg);
        BFF_A_FLAGW: st_nxt.rdat = {BFF_PACK_W'(st_r.afo[1]), BFF_PACK_W'(st_r.aeo[1]),
                                    BFF_PACK_W'(st_r.afo[0]), BFF_PACK_W'(st_r.aeo[0])};
        BFF_A_AE1: st_nxt.rdat = BFF_WORD_W'(st_r.aeo[0]);
        BFF_A_AF1: st_nxt.rdat = BFF_WORD_W'(st_r.afo[0]);
        BFF_A_AE2: st_nxt.rdat = BFF_WORD_W'(st_r.aeo[1]);
        BFF_A_AF2: st_nxt.rdat = BFF_WORD_W'(st_r.afo[1]);
        default: st_nxt.rdat = '0;
      endcase
    end
    // synchronous reset values
    if (RST_I) begin
      st_nxt = '0;
      st_nxt.cfg = BFF_CFG_RST;
      for (int f = 0; f < 2; f++) begin
        st_nxt.aeo[f] = OFS_W'(BFF_OFS_RST);
        st_nxt.afo[f] = OFS_W'(BFF_OFS_RST);
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // flag clocking selection
  // ---------------------------------------------------------------
  // sync enable and sync clock (0 port A, 1 port B) per flag
  assign sy[0] = {st_r.cfg[BFF_B_SY_EF1], st_r.cfg[BFF_B_SY_AE1],
                  st_r.cfg[BFF_B_HF1_LO] | st_r.cfg[BFF_B_HF1_HI],
                  st_r.cfg[BFF_B_SY_AF1], st_r.cfg[BFF_B_SY_FF1]};
  assign sy[1] = {st_r.cfg[BFF_B_SY_EF2], st_r.cfg[BFF_B_SY_AE2],
                  st_r.cfg[BFF_B_HF2_LO] | st_r.cfg[BFF_B_HF2_HI],
                  st_r.cfg[BFF_B_SY_AF2], st_r.cfg[BFF_B_SY_FF2]};
  assign sk[0] = {1'b1, 1'b0, ~st_r.cfg[BFF_B_HF1_LO], 1'b0, 1'b0};
  assign sk[1] = {1'b0, 1'b1, st_r.cfg[BFF_B_HF2_LO], 1'b1, 1'b1};

  // occupancy conditions and edge routing for each flag
  always_comb begin
    logic [SW-1:0] cx;
    int i;
    int s;
    int c;
    cx = '0;
    i = 0;
    s = 0;
    c = 0;
    for (int f = 0; f < 2; f++) begin
      cx = SW'(st_r.cnt[f]);
      cond[f*BFF_NFLAG+BFF_FL_FF] = (cx == SW'(DEPTH));
      cond[f*BFF_NFLAG+BFF_FL_AF] = (cx + SW'(st_r.afo[f])) >= SW'(DEPTH);
      cond[f*BFF_NFLAG+BFF_FL_HF] = (cx > SW'(DEPTH / 2));
      cond[f*BFF_NFLAG+BFF_FL_AE] = (cx <= SW'(st_r.aeo[f]));
      cond[f*BFF_NFLAG+BFF_FL_EF] = (cx == '0);
      for (int k = 0; k < BFF_NFLAG; k++) begin
        i = f * BFF_NFLAG + k;
        s = (k <= BFF_FL_HF) ? f : 1 - f;
        c = 1 - s;
        if (sy[f][k]) begin
          s = int'(sk[f][k]);
          c = s;
        end
        setr[i] = rise[s];
        clrr[i] = rise[c];
        clrf[i] = fall[c];
      end
    end
  end

  // ---------------------------------------------------------------
  // flag units
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2 * BFF_NFLAG; g++) begin : g_flag
    bff_flag_unit #(
      .RST_ASSERT((g % BFF_NFLAG) >= BFF_FL_AE)
    ) u_flag (
      .clk_i(REF_CLK_I),
      .rst_i(RST_I),
      .cond_i(cond[g]),
      .set_rise_i(setr[g]),
      .clr_rise_i(clrr[g]),
      .clr_fall_i(clrf[g]),
      .flag_n_o(flags_n[g])
    );
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign DATA_A_O = st_r.rdat;
  assign GEN_A_O = st_r.gena;
  assign GEN_B_O = st_r.genb;
  assign PARITY_ERROR_FLAG_A_N_O = st_r.cfg[BFF_B_LAT_A] ? ~st_r.pfa : ~now_a;
  assign PARITY_ERROR_FLAG_B_N_O = st_r.cfg[BFF_B_LAT_B] ? ~st_r.pfb : ~now_b;
  assign FLAGS1_N_O = bff_flags_t'(flags_n[BFF_NFLAG-1:0]);
  assign FLAGS2_N_O = bff_flags_t'(flags_n[2*BFF_NFLAG-1:BFF_NFLAG]);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ofs_reset: assert property (disable iff (RST_I) $fell(RST_I) |->
    (st_r.aeo[0] == OFS_W'(BFF_OFS_RST)) && (st_r.afo[1] == OFS_W'(BFF_OFS_RST)))
    else $error("offsets not eight after reset");
  a_cfg_reset: assert property (disable iff (RST_I) $fell(RST_I) |->
    (st_r.cfg == BFF_CFG_RST))
    else $error("configuration reset value wrong");
  a_pack_write: assert property (disable iff (RST_I)
    (wr_a && st_r.a2.addr == BFF_A_FLAGW) |=>
    (st_r.afo[1] == OFS_W'($past(st_r.a2.data[3*BFF_PACK_W +: BFF_PACK_W]))))
    else $error("packed offset write lost");
  a_check_a: assert property (disable iff (RST_I)
    !st_r.cfg[BFF_B_LAT_A] |-> (PARITY_ERROR_FLAG_A_N_O == (err_a == 4'h0)))
    else $error("port A flowthrough parity flag wrong");
  a_gen_odd: assert property (disable iff (RST_I)
    (st_r.cfg[BFF_B_GEN_A] && st_r.cfg[BFF_B_PSENSE]) ##1 $stable(st_r.cfg) |->
    (bff_par_err(GEN_A_O, 1'b1) == 4'h0))
    else $error("generated port A parity not odd");
  a_gen_pass: assert property (disable iff (RST_I)
    !st_r.cfg[BFF_B_GEN_B] |=> (GEN_B_O == $past(st_r.b2)))
    else $error("port B data altered with generation off");
  a_latch_hold: assert property (disable iff (RST_I)
    (st_r.cfg[BFF_B_LAT_B] && !rise[1]) ##1 $stable(st_r.cfg) |->
    $stable(PARITY_ERROR_FLAG_B_N_O))
    else $error("latched port B flag moved between edges");
  a_check_mask: assert property (disable iff (RST_I)
    (!st_r.cfg[BFF_B_CHK_B] && !st_r.cfg[BFF_B_LAT_B]) |->
    (PARITY_ERROR_FLAG_B_N_O == (err_b == 4'h0)))
    else $error("port B full-word check wrong");
  a_full_set: assert property (disable iff (RST_I)
    (st_r.cnt[0] == CW'(DEPTH) && setr[BFF_FL_FF]) |=> !FLAGS1_N_O.ff)
    else $error("full flag not asserted at depth");

  c_cfg_write: cover property (disable iff (RST_I) wr_a && st_r.a2.addr == BFF_A_CTRL);
  c_full: cover property (disable iff (RST_I) !FLAGS1_N_O.ff);
  c_perr_b: cover property (disable iff (RST_I) !PARITY_ERROR_FLAG_B_N_O && st_r.cfg[BFF_B_LAT_B]);
  c_ae_rel: cover property (disable iff (RST_I) $rose(FLAGS2_N_O.ae));

endmodule : bff_flag_parity

// File: verilog/bff_flag_unit.sv
// one status flag: set on one port edge, cleared via falling then rising edge
`timescale 1ns/10ps
module bff_flag_unit
  import bff_pkg::*;
#(
  parameter bit RST_ASSERT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cond_i,
  input wire logic set_rise_i,
  input wire logic clr_rise_i,
  input wire logic clr_fall_i,
  output logic flag_n_o
);

  typedef struct packed {
    logic flag_n;
    logic pend;
  } bff_fu_state_t;

  bff_fu_state_t st_r;
  bff_fu_state_t st_nxt;

  // ---------------------------------------------------------------
  // set and two-step clear
  // ---------------------------------------------------------------
  // assert on set-clock rise, arm clear on fall, release on rise
  always_comb begin
    st_nxt = st_r;
    if (rst_i) begin
      st_nxt.flag_n = ~RST_ASSERT;
      st_nxt.pend = 1'b0;
    end else if (cond_i) begin
      st_nxt.pend = 1'b0;
      if (set_rise_i) begin
        st_nxt.flag_n = 1'b0;
      end
    end else begin
      if (st_r.pend && clr_rise_i) begin
        st_nxt.flag_n = 1'b1;
        st_nxt.pend = 1'b0;
      end else if (clr_fall_i && !st_r.flag_n) begin
        st_nxt.pend = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign flag_n_o = st_r.flag_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_set_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (cond_i && set_rise_i) |=> !flag_n_o)
    else $error("flag not asserted on set edge");

  a_clr_order: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_n_o) |-> ($past(st_r.pend) && $past(clr_rise_i) && !$past(cond_i)))
    else $error("flag released without armed clear");

endmodule : bff_flag_unit
